// file: design/timer16_pwm_waveform_modes.sv
`timescale 1ns/1ps
// Notes on behaviour
// - capture top unbuffered; missed match wraps past ffff in fast pwm, turns at ffff in dual slope
// - compare a writes land in buffer
// - fast pwm: buffer loads at top match
// - action two non-inverted, three inverted
// - fast pwm: clear at match, restore at bottom
// - pin driven only when direction is output
// - fast pwm period is top plus one
// - fast pwm: compare zero spikes; compare top gives constant
// - select 15 toggle action on channel a halves frequency
// - selects 1,2,3,10,11 are dual slope
// - top per select; holds top one tick
// - dual slope: clear up, set down
// - dual slope: overflow flag at bottom
// - top flag with buffer load at top
// - fixed top masks compare write bits
// - compare flag whenever count equals compare
// - falling slope old top, rising new
// - dual slope period is twice top
// - dual slope extremes give constant levels
// - selects 5,6,7,14,15 are single slope
// - fast pwm: overflow flag at top
// - select 11 toggle action on channel a gives half duty
module timer16_pwm_waveform_modes #(
    parameter int unsigned CNT_W = pwm16_pkg::CNT_W
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    clk_en_i,          // freezes all state while low
    input  wire logic                    tick_i,            // prescaler timer-clock enable
    input  wire logic [3:0]              waveform_select_i,
    input  wire pwm16_pkg::chan_ctrl_s   ctrl_a_i,
    input  wire pwm16_pkg::chan_ctrl_s   ctrl_b_i,
    input  wire logic                    cmp_a_wr_i,        // compare a write strobe
    input  wire logic                    cmp_b_wr_i,        // compare b write strobe
    input  wire logic                    cap_wr_i,          // capture top write strobe
    input  wire logic [CNT_W-1:0]        wr_data_i,
    input  wire logic                    pin_a_port_i,      // port level when not overridden
    input  wire logic                    pin_b_port_i,
    output logic [CNT_W-1:0]             count_value_o,
    output logic [CNT_W-1:0]             compare_a_value_o, // active compare a
    output logic [CNT_W-1:0]             compare_b_value_o,
    output logic [CNT_W-1:0]             capture_top_value_o,
    output pwm16_pkg::event_flags_s      flags_o,           // one-cycle pulses
    output logic                         count_down_o,
    output logic                         wave_output_a_o,
    output logic                         wave_output_b_o,
    output logic                         pin_a_o,
    output logic                         pin_a_oe_n_o,      // low while driving
    output logic                         pin_b_o,
    output logic                         pin_b_oe_n_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count_q,  count_d;   // running counter
    logic             down_q,   down_d;    // dual-slope direction
    logic [CNT_W-1:0] buf_a_q,  buf_a_d;   // compare a buffer
    logic [CNT_W-1:0] buf_b_q,  buf_b_d;   // compare b buffer
    logic [CNT_W-1:0] act_a_q,  act_a_d;   // active compare a
    logic [CNT_W-1:0] act_b_q,  act_b_d;   // active compare b
    logic [CNT_W-1:0] cap_q,    cap_d;     // capture register used as top
    logic             wave_a_q, wave_a_d;
    logic             wave_b_q, wave_b_d;
    pwm16_pkg::event_flags_s flags_q, flags_d;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire logic [3:0] ws = waveform_select_i;
    wire logic mode_pc = (ws == pwm16_pkg::WS_PC8) || (ws == pwm16_pkg::WS_PC9)
                      || (ws == pwm16_pkg::WS_PC10) || (ws == pwm16_pkg::WS_PC_CAP)
                      || (ws == pwm16_pkg::WS_PC_CMPA);
    wire logic mode_fp = (ws == pwm16_pkg::WS_FP8) || (ws == pwm16_pkg::WS_FP9)
                      || (ws == pwm16_pkg::WS_FP10) || (ws == pwm16_pkg::WS_FP_CAP)
                      || (ws == pwm16_pkg::WS_FP_CMPA);
    wire logic top_cap  = (ws == pwm16_pkg::WS_PC_CAP)  || (ws == pwm16_pkg::WS_FP_CAP);
    wire logic top_cmpa = (ws == pwm16_pkg::WS_PC_CMPA) || (ws == pwm16_pkg::WS_FP_CMPA);

    // fixed-top resolution mask; all ones when top comes from a register
    wire logic [CNT_W-1:0] res_mask =
        ((ws == pwm16_pkg::WS_PC8)  || (ws == pwm16_pkg::WS_FP8))  ? CNT_W'(pwm16_pkg::TOP_8BIT)  :
        ((ws == pwm16_pkg::WS_PC9)  || (ws == pwm16_pkg::WS_FP9))  ? CNT_W'(pwm16_pkg::TOP_9BIT)  :
        ((ws == pwm16_pkg::WS_PC10) || (ws == pwm16_pkg::WS_FP10)) ? CNT_W'(pwm16_pkg::TOP_10BIT) :
        CNT_W'(pwm16_pkg::MAX_VAL);

    // top selection; register tops are live, fixed tops equal the mask
    wire logic [CNT_W-1:0] top_val = top_cap  ? cap_q   :
                                     top_cmpa ? act_a_q : res_mask;

    // masked write data for compare registers
    wire logic [CNT_W-1:0] wr_masked = wr_data_i & res_mask;

    // ------------------------------------------------------------
    // counter events
    // ------------------------------------------------------------
    // exact equality only: a top written below the count is missed and the
    // counter runs on to all ones, then wraps in fast pwm or turns in dual slope
    wire logic at_top    = (count_q == top_val);
    wire logic at_max    = (count_q == CNT_W'(pwm16_pkg::MAX_VAL));
    wire logic at_bottom = (count_q == CNT_W'(pwm16_pkg::BOTTOM_VAL));
    wire logic match_a   = (count_q == act_a_q);
    wire logic match_b   = (count_q == act_b_q);
    wire logic wrap_fp   = mode_fp && (at_top || at_max);
    // dual slope turns at top; a missed top still turns at all ones
    wire logic turn_pc   = mode_pc && !down_q && (at_top || at_max);
    // dual slope overflow fires once per period, on the tick spent at bottom;
    // flagging the step into bottom as well would give two pulses a period
    wire logic bot_pc    = mode_pc && down_q && at_bottom;
    // buffer load point: top in both pwm families
    wire logic load_pt   = mode_fp ? at_top : (mode_pc && !down_q && at_top);

    // ------------------------------------------------------------
    // counter next state
    // ------------------------------------------------------------
    // fast pwm clears after top; dual slope holds top one tick then reverses
    always_comb begin
        count_d = count_q;
        down_d  = down_q;
        if (mode_fp) begin
            down_d  = 1'b0;
            count_d = wrap_fp ? CNT_W'(pwm16_pkg::BOTTOM_VAL) : count_q + CNT_W'(1);
        end else if (mode_pc) begin
            if (turn_pc) begin
                down_d  = 1'b1;
                count_d = count_q - CNT_W'(1);
            end else if (down_q && at_bottom) begin
                down_d  = 1'b0;
                count_d = count_q + CNT_W'(1);
            end else if (down_q) begin
                count_d = count_q - CNT_W'(1);
            end else begin
                count_d = count_q + CNT_W'(1);
            end
        end else begin
            // modes outside this block: plain up count
            down_d  = 1'b0;
            count_d = count_q + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // double buffer and capture register
    // ------------------------------------------------------------
    // writes always go to the buffer; in the pwm modes the active copy moves at top only.
    // the capture register has no buffer, so a write takes effect at once
    always_comb begin
        buf_a_d = cmp_a_wr_i ? wr_masked : buf_a_q;
        buf_b_d = cmp_b_wr_i ? wr_masked : buf_b_q;
        cap_d   = cap_wr_i   ? wr_data_i : cap_q;
        act_a_d = act_a_q;
        act_b_d = act_b_q;
        if (tick_i && load_pt) begin
            act_a_d = buf_a_q;
            act_b_d = buf_b_q;
        end else if (!(mode_fp || mode_pc)) begin
            // no buffering outside the pwm modes
            act_a_d = buf_a_q;
            act_b_d = buf_b_q;
        end
    end

    // ------------------------------------------------------------
    // waveform logic, one function for both channels
    // ------------------------------------------------------------
    function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                       input logic mt, input logic is_a,
                                       input logic [CNT_W-1:0] cmp);
        logic nv;
        nv = cur;
        if (act == pwm16_pkg::ACT_TOGGLE) begin
            // toggle only for channel a with compare a as top
            if (is_a && top_cmpa && mt) begin
                nv = !cur;
            end
        end else if (act[1]) begin
            if (mode_fp) begin
                // match to the active level wins over bottom restore, so a
                // compare of top gives a constant level
                if (mt) begin
                    nv = act[0];
                end else if (at_top || at_max) begin
                    nv = !act[0];
                end
            end else if (mode_pc && mt) begin
                // up-count match clears, down-count match sets
                nv = (down_q || (turn_pc && !at_top)) ? !act[0] : act[0];
                if (!down_q && cmp == top_val) begin
                    nv = !act[0];
                end
                if (cmp == CNT_W'(pwm16_pkg::BOTTOM_VAL)) begin
                    nv = act[0];
                end
            end
        end
        return nv;
    endfunction

    // period figures are emergent from the counter sequence
    always_comb begin
        wave_a_d = wave_next(wave_a_q, ctrl_a_i.action, match_a, 1'b1, act_a_q);
        wave_b_d = wave_next(wave_b_q, ctrl_b_i.action, match_b, 1'b0, act_b_q);
    end

    // ------------------------------------------------------------
    // flags: one-cycle pulses in the tick where the event occurs
    // ------------------------------------------------------------
    always_comb begin
        flags_d           = '0;
        flags_d.overflow  = tick_i && (mode_fp ? at_top : (mode_pc ? bot_pc : at_max));
        flags_d.compare_a = tick_i && match_a;
        flags_d.compare_b = tick_i && match_b;
        flags_d.capture   = tick_i && top_cap && load_pt;
    end

    // ------------------------------------------------------------
    // registers; timer state moves only on the timer enable
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            count_q  <= pwm16_pkg::RST_COUNT;
            down_q   <= 1'b0;
            buf_a_q  <= pwm16_pkg::RST_COMPARE;
            buf_b_q  <= pwm16_pkg::RST_COMPARE;
            act_a_q  <= pwm16_pkg::RST_COMPARE;
            act_b_q  <= pwm16_pkg::RST_COMPARE;
            cap_q    <= pwm16_pkg::RST_COMPARE;
            wave_a_q <= pwm16_pkg::RST_WAVE;
            wave_b_q <= pwm16_pkg::RST_WAVE;
            flags_q  <= '0;
        end else if (clk_en_i) begin
            buf_a_q <= buf_a_d;
            buf_b_q <= buf_b_d;
            cap_q   <= cap_d;
            act_a_q <= act_a_d;
            act_b_q <= act_b_d;
            flags_q <= flags_d;
            if (tick_i) begin
                count_q  <= count_d;
                down_q   <= down_d;
                wave_a_q <= wave_a_d;
                wave_b_q <= wave_b_d;
            end
        end
    end

    // ------------------------------------------------------------
    // pin override: driven only with output direction
    // ------------------------------------------------------------
    wire logic ovr_a = (ctrl_a_i.action != pwm16_pkg::ACT_OFF);
    wire logic ovr_b = (ctrl_b_i.action != pwm16_pkg::ACT_OFF);

    assign pin_a_o      = ovr_a ? wave_a_q : pin_a_port_i;
    assign pin_b_o      = ovr_b ? wave_b_q : pin_b_port_i;
    assign pin_a_oe_n_o = !ctrl_a_i.dir_out;
    assign pin_b_oe_n_o = !ctrl_b_i.dir_out;

    assign count_value_o       = count_q;
    assign compare_a_value_o   = act_a_q;
    assign compare_b_value_o   = act_b_q;
    assign capture_top_value_o = cap_q;
    assign flags_o             = flags_q;
    assign count_down_o        = down_q;
    assign wave_output_a_o     = wave_a_q;
    assign wave_output_b_o     = wave_b_q;

endmodule

// file: design/pwm16_pkg.sv
package pwm16_pkg;

    // ------------------------------------------------------------
    // widths and fixed values
    // ------------------------------------------------------------
    localparam int unsigned          CNT_W      = 16;
    localparam logic [15:0]          BOTTOM_VAL = 16'h0000;
    localparam logic [15:0]          MAX_VAL    = 16'hffff;
    localparam logic [15:0]          TOP_8BIT   = 16'h00ff;
    localparam logic [15:0]          TOP_9BIT   = 16'h01ff;
    localparam logic [15:0]          TOP_10BIT  = 16'h03ff;
    localparam logic [15:0]          MIN_REG_TOP = 16'h0003; // least legal register top

    // ------------------------------------------------------------
    // waveform select codes
    // ------------------------------------------------------------
    localparam logic [3:0] WS_PC8     = 4'h1;
    localparam logic [3:0] WS_PC9     = 4'h2;
    localparam logic [3:0] WS_PC10    = 4'h3;
    localparam logic [3:0] WS_FP8     = 4'h5;
    localparam logic [3:0] WS_FP9     = 4'h6;
    localparam logic [3:0] WS_FP10    = 4'h7;
    localparam logic [3:0] WS_PC_CAP  = 4'ha;
    localparam logic [3:0] WS_PC_CMPA = 4'hb;
    localparam logic [3:0] WS_FP_CAP  = 4'he;
    localparam logic [3:0] WS_FP_CMPA = 4'hf;

    // ------------------------------------------------------------
    // output action select codes
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [1:0] ACT_INV    = 2'h3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_COUNT   = 16'h0000;
    localparam logic [15:0] RST_COMPARE = 16'h0000;
    localparam logic        RST_WAVE    = 1'b0;

    // per-channel control bundle
    typedef struct packed {
        logic [1:0] action;   // output action select
        logic       dir_out;  // pin direction bit, 1 = output
    } chan_ctrl_s;

    // per-cycle event flags, one-cycle pulses
    typedef struct packed {
        logic overflow;
        logic compare_a;
        logic compare_b;
        logic capture;
    } event_flags_s;

endpackage

// file: sim/pwm16_sva.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// waveform and counter checks, one timer clock domain
// ---------------------------------------------------------------
module pwm16_sva #(
    parameter int unsigned CNT_W = 16
) (
    input wire logic                    core_clk_i,
    input wire logic                    rst_i,
    input wire logic                    clk_en_i,
    input wire logic                    tick_i,
    input wire logic [3:0]              waveform_select_i,
    input wire pwm16_pkg::chan_ctrl_s   ctrl_a_i,
    input wire logic [CNT_W-1:0]        count_value_o,
    input wire logic [CNT_W-1:0]        compare_a_value_o,
    input wire logic [CNT_W-1:0]        capture_top_value_o,
    input wire pwm16_pkg::event_flags_s flags_o,
    input wire logic                    count_down_o,
    input wire logic                    wave_output_a_o,
    input wire logic                    pin_a_o,
    input wire logic                    pin_a_oe_n_o
);
    wire logic             step_w = clk_en_i & tick_i;  // timer advances on this edge
    wire logic [3:0]       ws_w   = waveform_select_i;
    wire logic [1:0]       act_w  = ctrl_a_i.action;
    wire logic             fp_w   = ws_w inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
    wire logic             pc_w   = ws_w inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
    // odd register-top selects take compare a, even ones the capture register
    wire logic [CNT_W-1:0] top_w  = ws_w[3] ? (ws_w[0] ? compare_a_value_o : capture_top_value_o)
                                  : (ws_w[1:0] == 2'h1) ? pwm16_pkg::TOP_8BIT
                                  : (ws_w[1:0] == 2'h2) ? pwm16_pkg::TOP_9BIT : pwm16_pkg::TOP_10BIT;
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // ---------------------------------------------------------------
    // named steps
    // ---------------------------------------------------------------
    sequence fp_top_s;
        step_w && fp_w && count_value_o == top_w;
    endsequence
    // mid-slope match; both turning points are left out on purpose
    sequence pc_mid_s;
        step_w && pc_w && act_w[1] && count_value_o == compare_a_value_o
            && count_value_o != top_w && count_value_o != 16'h0000;
    endsequence
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    hold_idle_a: assert property (!step_w |=> $stable(count_value_o))
        else $error("count moved without a timer tick");
    fast_wrap_a: assert property (fp_top_s |=> count_value_o == 16'h0000 && flags_o.overflow)
        else $error("fast mode did not wrap with overflow at top");
    // a compare equal to top keeps the match level, so the restore is not expected there
    fast_restore_a: assert property (fp_top_s ##0 act_w[1] && compare_a_value_o != top_w
        |=> wave_output_a_o == !$past(act_w[0]))
        else $error("fast mode wave not restored at top");
    fast_match_a: assert property (step_w && fp_w && act_w[1]
        && count_value_o == compare_a_value_o && count_value_o != top_w
        |=> wave_output_a_o == $past(act_w[0]))
        else $error("fast mode wave wrong after match");
    dual_turn_a: assert property (step_w && pc_w && count_value_o == top_w
        && count_value_o != 16'h0000 |=> count_value_o == $past(count_value_o) - 16'h0001)
        else $error("dual slope did not turn after one tick at top");
    dual_up_a: assert property (pc_mid_s ##0 !count_down_o |=> wave_output_a_o == $past(act_w[0]))
        else $error("dual slope wave wrong on up match");
    dual_down_a: assert property (pc_mid_s ##0 count_down_o |=> wave_output_a_o == !$past(act_w[0]))
        else $error("dual slope wave wrong on down match");
    match_flag_a: assert property (step_w && count_value_o == compare_a_value_o |=> flags_o.compare_a)
        else $error("compare a flag missing on match");
    toggle_wave_a: assert property (step_w && ws_w inside {4'hb, 4'hf} && act_w == 2'h1
        && count_value_o == compare_a_value_o |=> wave_output_a_o != $past(wave_output_a_o))
        else $error("wave a did not toggle on match");
    pin_drive_a: assert property (ctrl_a_i.dir_out && act_w != 2'h0
        |-> pin_a_o == wave_output_a_o && !pin_a_oe_n_o)
        else $error("pin a not driven with wave");
endmodule

bind timer16_pwm_waveform_modes pwm16_sva #(.CNT_W(CNT_W)) pwm16_sva_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .tick_i(tick_i),
    .waveform_select_i(waveform_select_i), .ctrl_a_i(ctrl_a_i), .count_value_o(count_value_o),
    .compare_a_value_o(compare_a_value_o), .capture_top_value_o(capture_top_value_o),
    .flags_o(flags_o), .count_down_o(count_down_o), .wave_output_a_o(wave_output_a_o),
    .pin_a_o(pin_a_o), .pin_a_oe_n_o(pin_a_oe_n_o));

// file: sim/pin_load_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// load on a waveform pin, pulled up when nobody drives it
// ---------------------------------------------------------------
module pin_load_model (
    input  wire logic core_clk_i,
    input  wire logic drive_i,  // level offered by the pin driver
    input  wire logic oe_n_i,   // low while the driver is on
    output logic      line_o,   // level the load sees
    output int        rises_o   // rising edges counted so far
);
    logic prev_q  = 1'b1;  // line level one clock ago, idle level of the pull-up
    int   rises_q = 0;     // rising edges seen
    // a released pin shows the pull-up, never the last driven level
    assign line_o  = oe_n_i ? 1'b1 : drive_i;
    assign rises_o = rises_q;
    // edge counter; the bench reads differences over fixed windows
    always @(posedge core_clk_i) begin
        if (line_o && !prev_q) begin
            rises_q <= rises_q + 1;
        end
        prev_q <= line_o;
    end
endmodule

// file: sim/timer16_pwm_waveform_modes_tb.sv
`timescale 1ns/1ps
module timer16_pwm_waveform_modes_tb;
    // ---------------------------------------------------------------
    // stimulus and observation
    // ---------------------------------------------------------------
    logic                    core_clk_i = 1'b0;
    logic                    rst_i      = 1'b1;
    logic                    tick_on    = 1'b0;  // lets the prescaler enable run
    logic                    slow       = 1'b0;  // tick on every other clock
    logic                    tick_i     = 1'b0;
    logic [3:0]              ws         = 4'h0;
    pwm16_pkg::chan_ctrl_s   ctrl_a     = '0;
    pwm16_pkg::chan_ctrl_s   ctrl_b     = '{2'h0, 1'b1};
    logic [2:0]              wr         = 3'h0;  // capture, compare b, compare a strobes
    logic [15:0]             wr_data    = 16'h0000;
    logic                    port_b     = 1'b1;
    logic [15:0]             count, cmp_a, cmp_b, cap;
    pwm16_pkg::event_flags_s flags;
    logic                    down, wave_a, wave_b, pin_a, oe_a_n, pin_b, oe_b_n, line_a;
    int                      rises, n_errors = 0, n_compared = 0, cycles = 0;
    // period table: mode, flag bit, period, top
    logic [3:0]  modes [9] = '{4'h5, 4'h6, 4'h7, 4'h1, 4'h2, 4'h3, 4'he, 4'ha, 4'ha};
    int          fbit  [9] = '{3, 3, 3, 3, 3, 3, 3, 3, 0};
    logic [15:0] pers  [9] = '{16'h0100, 16'h0200, 16'h0400, 16'h01fe, 16'h03fe, 16'h07fe,
                               16'h0011, 16'h0020, 16'h0020};
    logic [15:0] tops  [9] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h00ff, 16'h01ff, 16'h03ff,
                               16'h0010, 16'h0010, 16'h0010};
    // edge table: mode, action, compare, rises in 544 clocks
    // the last entry matches mid-slope on both the rising and falling count
    logic [3:0]  emod  [9] = '{4'hf, 4'hb, 4'he, 4'ha, 4'ha, 4'ha, 4'ha, 4'he, 4'ha};
    logic [1:0]  eact  [9] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2};
    logic [15:0] ecmp  [9] = '{16'h0003, 16'h0008, 16'h0000, 16'h0000, 16'h0010, 16'h0000,
                               16'h0010, 16'h0010, 16'h0008};
    logic [15:0] erise [9] = '{16'h0044, 16'h0011, 16'h0020, 16'h0000, 16'h0000, 16'h0000,
                               16'h0000, 16'h0000, 16'h0011};

    timer16_pwm_waveform_modes timer16_pwm_waveform_modes_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(1'b1), .tick_i(tick_i),
        .waveform_select_i(ws), .ctrl_a_i(ctrl_a), .ctrl_b_i(ctrl_b), .cmp_a_wr_i(wr[0]),
        .cmp_b_wr_i(wr[1]), .cap_wr_i(wr[2]), .wr_data_i(wr_data), .pin_a_port_i(1'b0),
        .pin_b_port_i(port_b), .count_value_o(count), .compare_a_value_o(cmp_a),
        .compare_b_value_o(cmp_b), .capture_top_value_o(cap), .flags_o(flags),
        .count_down_o(down), .wave_output_a_o(wave_a), .wave_output_b_o(wave_b),
        .pin_a_o(pin_a), .pin_a_oe_n_o(oe_a_n), .pin_b_o(pin_b), .pin_b_oe_n_o(oe_b_n));
    pin_load_model pin_load_model_i (
        .core_clk_i(core_clk_i), .drive_i(pin_a), .oe_n_i(oe_a_n), .line_o(line_a),
        .rises_o(rises));

    // ---------------------------------------------------------------
    // clock, prescaler enable and hang guard
    // ---------------------------------------------------------------
    initial forever #2 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) tick_i <= tick_on & (~slow | ~tick_i);
    always @(posedge core_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 99000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end

    // ---------------------------------------------------------------
    // access and compare tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic write(input logic [2:0] sel, input logic [15:0] d);
        @(posedge core_clk_i);
        wr      <= sel;
        wr_data <= d;
        @(posedge core_clk_i);
        wr <= 3'h0;
    endtask
    // writes go in while the timer is stopped in plain mode, so they land at once
    task automatic setup(input logic [3:0] mode, input logic [1:0] act, input logic [15:0] d);
        @(posedge core_clk_i);
        rst_i   <= 1'b1;
        tick_on <= 1'b0;
        slow    <= 1'b0;
        ws      <= 4'h0;
        ctrl_a  <= '{act, 1'b1};
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        write(3'h1, d);
        write(3'h4, 16'h0010);
        ws      <= mode;
        tick_on <= 1'b1;
    endtask
    task automatic wait_count(input logic [15:0] v);
        for (int i = 0; i < 66000 && count !== v; i++) @(negedge core_clk_i);
    endtask
    task automatic meas(input int idx, output int per, output logic [15:0] mx);
        per = 0;
        mx  = 16'h0000;
        do @(negedge core_clk_i); while (flags[idx] !== 1'b1);
        do begin
            @(negedge core_clk_i);
            per++;
            if (count > mx) mx = count;
        end while (flags[idx] !== 1'b1 && per < 5000);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        int          per;
        int          r0;
        logic [15:0] mx;
        repeat (8) @(posedge core_clk_i);
        for (int i = 0; i < 9; i++) begin
            setup(modes[i], 2'h2, 16'h0000);
            meas(fbit[i], per, mx);
            check("period", per[15:0], pers[i]);
            check("top", mx, tops[i]);
            check("direction", {15'h0000, down}, {15'h0000, i == 8});
        end
        for (int i = 0; i < 9; i++) begin
            setup(emod[i], eact[i], ecmp[i]);
            repeat (40) @(negedge core_clk_i);
            r0 = rises;
            repeat (544) @(negedge core_clk_i);
            check("rises", 16'(rises - r0), erise[i]);
            // dual slope: bottom low, top high, inverted flips; fast top keeps match level
            if (i > 2 && i < 8) begin
                check("level", {15'h0000, line_a}, {15'h0000, i == 4 || i == 5});
            end
        end
        // buffered compare, masking and pin release
        setup(4'h5, 2'h2, 16'h0000);
        write(3'h1, 16'h1234);
        write(3'h2, 16'h0abc);
        @(negedge core_clk_i);
        check("buffered compare", cmp_a, 16'h0000);
        wait_count(16'h00ff);
        @(negedge core_clk_i);
        check("loaded compare", cmp_a, 16'h0034);
        check("loaded compare b", cmp_b, 16'h00bc);
        check("capture top", cap, 16'h0010);
        wait_count(16'h0010);
        check("pin high", {15'h0000, line_a}, 16'h0001);
        wait_count(16'h0040);
        check("pin low", {15'h0000, line_a}, 16'h0000);
        @(posedge core_clk_i);
        ctrl_a.dir_out <= 1'b0;
        @(negedge core_clk_i);
        check("released pin", {14'h0000, line_a, oe_a_n}, 16'h0003);
        check("port pin b", {14'h0000, pin_b, oe_b_n}, 16'h0002);
        // timer enable on every other clock doubles the period
        setup(4'h5, 2'h2, 16'h0000);
        slow <= 1'b1;
        meas(3, per, mx);
        check("slow period", per[15:0], 16'h0200);
        // capture top written below the count is missed until wrap
        setup(4'he, 2'h2, 16'h0000);
        wait_count(16'h000c);
        write(3'h4, 16'h0005);
        wait_count(16'hffff);
        check("wrapped count", count, 16'hffff);
        tally_and_finish();
    end
endmodule
